// file: include/nmcrc_defines.vh
`ifndef NMCRC_DEFINES_VH
`define NMCRC_DEFINES_VH
`define NMCRC_PAR_W 24
`define NMCRC_INFO_BITS 276
`define NMCRC_POLY 24'h864cfb
`define NMCRC_SEED 24'h000000
`define NMCRC_MSB 23
`define NMCRC_CNT_W 9
`define NMCRC_PCNT_W 5
`define NMCRC_PAR_LAST 5'h17
`define NMCRC_ST_IDLE 2'h0
`define NMCRC_ST_INFO 2'h1
`define NMCRC_ST_PAR 2'h2
`endif

// file: design/nmcrc_step.v
`timescale 1ns/1ns
`include "nmcrc_defines.vh"
`default_nettype none
module nmcrc_step (
    input wire [23:0] rem_in,
    input wire bit_in,
    output wire [23:0] rem_out
);
    wire fb;
    // Forward-direction divider; the top coefficient leaves first.
    assign fb = rem_in[`NMCRC_MSB] ^ bit_in; // [R4]
    assign rem_out = {rem_in[22:0], 1'b0} ^ (fb ? `NMCRC_POLY : `NMCRC_SEED); // [R3] [R5]
endmodule
`default_nettype wire

// file: design/nmcrc_top.v
`timescale 1ns/1ns
`include "nmcrc_defines.vh"
`default_nettype none
// Functional notes
// [R1] Exactly 24 parity bits per message from its 276 information bits in order.
// [R2] Remainder cleared to zero before each message; bits processed first-sent first.
// [R3] Generator is (1+X) times the degree-23 primitive polynomial.
// [R4] First information bit carries the highest polynomial power.
// [R5] Parity is remainder of message times X^24 divided by generator.
// [R6] Parity bit i, counted from 0, is remainder coefficient at power 23 minus i.
// [R7] Checker catches single, double and any odd number of bit errors.
// [R8] Checker catches every burst error of 24 bits or fewer.
// [R9] Check mode compares remainder with received parity; one-cycle error pulse on mismatch.
// [R10] Framer sends one valid bit per cycle with start marker, then drops in_valid until its next message without waiting for parity.
module nmcrc_top #(
    parameter INFO_BITS = `NMCRC_INFO_BITS
) (
    input wire clk,
    input wire rst,
    input wire check_mode,
    input wire in_valid,
    input wire in_start,
    input wire in_bit,
    output reg out_valid,
    output reg out_bit,
    output reg out_parity,
    output reg msg_done,
    output reg crc_error,
    output reg busy
);
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [23:0] rem_r;
    reg [23:0] rem_nxt;
    reg [8:0] cnt_r;
    reg [8:0] cnt_nxt;
    reg [4:0] pcnt_r;
    reg [4:0] pcnt_nxt;
    reg mism_r;
    reg mism_nxt;
    reg cmode_r;
    reg cmode_nxt;
    wire [23:0] step_seed;
    wire [23:0] step_rem;
    wire step_bit;
    wire [8:0] last_idx;
    wire [31:0] last_full;

    // The count is held in a narrow counter, so the index is cut to its width on purpose.
    assign last_full = INFO_BITS - 1;
    assign last_idx = last_full[8:0];
    // A start marker restarts from the zero seed except in the parity phase, so a stray marker among the information bits resynchronises.
    assign step_seed = (in_valid && in_start) ? `NMCRC_SEED : rem_r; // [R2]
    assign step_bit = in_bit;

    nmcrc_step u_step (
        .rem_in(step_seed),
        .bit_in(step_bit),
        .rem_out(step_rem)
    );

    always @* begin
        state_nxt = state_r;
        rem_nxt = rem_r;
        cnt_nxt = cnt_r;
        pcnt_nxt = pcnt_r;
        mism_nxt = mism_r;
        cmode_nxt = cmode_r;
        if (in_valid && in_start && state_r != `NMCRC_ST_PAR) begin
            rem_nxt = step_rem; // [R2] [R4]
            cnt_nxt = 9'h001;
            cmode_nxt = check_mode;
            mism_nxt = 1'b0;
            state_nxt = (last_idx == 9'h000) ? `NMCRC_ST_PAR : `NMCRC_ST_INFO;
            pcnt_nxt = 5'h00;
        end else begin
            case (state_r)
                `NMCRC_ST_IDLE: begin
                    state_nxt = `NMCRC_ST_IDLE;
                end
                `NMCRC_ST_INFO: begin
                    if (in_valid) begin
                        rem_nxt = step_rem; // [R5]
                        cnt_nxt = cnt_r + 9'h001;
                        if (cnt_r == last_idx) begin
                            state_nxt = `NMCRC_ST_PAR; // [R1]
                            pcnt_nxt = 5'h00;
                        end
                    end
                end
                `NMCRC_ST_PAR: begin
                    // In generate mode the parity is shifted out unprompted; in check mode each
                    // received parity bit must be qualified by in_valid.
                    if (!cmode_r || in_valid) begin
                        rem_nxt = {rem_r[22:0], 1'b0}; // [R6]
                        pcnt_nxt = pcnt_r + 5'h01;
                        if (cmode_r && (in_bit != rem_r[`NMCRC_MSB])) begin
                            mism_nxt = 1'b1; // [R7] [R8]
                        end
                        if (pcnt_r == `NMCRC_PAR_LAST) begin
                            state_nxt = `NMCRC_ST_IDLE; // [R1] [R10]
                        end
                    end
                end
                default: begin
                    state_nxt = `NMCRC_ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= `NMCRC_ST_IDLE;
            rem_r <= `NMCRC_SEED;
            cnt_r <= 9'h000;
            pcnt_r <= 5'h00;
            mism_r <= 1'b0;
            cmode_r <= 1'b0;
            out_valid <= 1'b0;
            out_bit <= 1'b0;
            out_parity <= 1'b0;
            msg_done <= 1'b0;
            crc_error <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rem_r <= rem_nxt;
            cnt_r <= cnt_nxt;
            pcnt_r <= pcnt_nxt;
            mism_r <= mism_nxt;
            cmode_r <= cmode_nxt;
            busy <= (state_nxt != `NMCRC_ST_IDLE);
            out_valid <= 1'b0;
            out_parity <= 1'b0;
            msg_done <= 1'b0;
            crc_error <= 1'b0;
            if (state_r == `NMCRC_ST_PAR && (!cmode_r || in_valid)) begin
                out_valid <= 1'b1;
                out_parity <= 1'b1;
                // Generate mode outputs the computed bit; check mode echoes the received bit.
                out_bit <= cmode_r ? in_bit : rem_r[`NMCRC_MSB]; // [R6]
                if (pcnt_r == `NMCRC_PAR_LAST) begin
                    msg_done <= 1'b1;
                    crc_error <= cmode_r & (mism_nxt); // [R9]
                end
            end else if (in_valid && (state_r == `NMCRC_ST_INFO || (in_start && state_r != `NMCRC_ST_PAR))) begin
                out_valid <= 1'b1;
                out_bit <= in_bit;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/nmcrc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module nmcrc_checker #(parameter INFO_BITS = 276) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic out_valid,
    input wire logic out_parity,
    input wire logic msg_done,
    input wire logic crc_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_err_done: assert property (crc_error |-> msg_done) else $error("error flag without done");
    a_par_valid: assert property (out_parity |-> out_valid) else $error("parity without valid");
    a_done_par: assert property (msg_done |-> out_parity) else $error("done off parity");
    a_echo_valid: assert property (out_valid && !out_parity |-> $past(in_valid)) else $error("echo without bit");
    a_done_pulse: assert property (msg_done |=> !msg_done) else $error("done too long");
    a_err_pulse: assert property (crc_error |=> !crc_error) else $error("error too long");
    a_par_first: assert property ($rose(out_parity) |-> !msg_done) else $error("parity run too short");
    a_err_valid: assert property (crc_error |-> out_valid) else $error("error without valid");
endmodule
bind nmcrc_top nmcrc_checker #(.INFO_BITS(INFO_BITS)) u_chk (.clk, .rst, .in_valid, .out_valid, .out_parity,
    .msg_done, .crc_error);
`default_nettype wire

// file: verification/nmcrc_framer.sv
`timescale 1ns/1ns
`default_nettype none
module nmcrc_framer (
    input wire logic clk,
    output logic in_valid = 1'b0,
    output logic in_start = 1'b0,
    output logic in_bit = 1'b0
);
    task automatic send(input logic [299:0] d, input int n);
        for (int i = 0; i < n; i++)
            @(negedge clk) {in_valid, in_start, in_bit} = {1'b1, i == 0, d[i]};
        @(negedge clk) {in_valid, in_bit} = {1'b0, ~in_bit}; // Idle data is inverted so a stale bit never looks live.
    endtask
endmodule
`default_nettype wire

// file: verification/nmcrc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nmcrc_top_tb_top;
    logic clk = 1'b0, rst = 1'b1, check_mode = 1'b0;
    wire in_valid, in_start, in_bit, out_valid, out_bit, out_parity, msg_done, crc_error, busy;
    int err_total = 0, comparisons = 0;
    logic [299:0] a = {25{12'h5c3}};
    always #10 clk = ~clk;
    nmcrc_top u_dut (.clk, .rst, .check_mode, .in_valid, .in_start, .in_bit, .out_valid, .out_bit, .out_parity,
        .msg_done, .crc_error, .busy);
    nmcrc_framer u_frm (.clk, .in_valid, .in_start, .in_bit);
    task automatic chk(input logic [25:0] g, input logic [25:0] e);
        comparisons++;
        err_total += g !== e;
        if (g !== e) $display("ERROR %0t got %h expected %h", $time, g, e);
    endtask
    task automatic finish_test(input int extra);
        err_total += extra;
        if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic run(input logic m, input logic [299:0] k, input logic [299:0] x);
        logic [23:0] e = 24'h000000;
        logic [299:0] d;
        logic [25:0] c = 26'h0000000;
        logic [9:0] n = 10'h000;
        for (int i = 0; i < 276; i++) e = {e[22:0], 1'b0} ^ (e[23] ^ k[i] ? 24'h864cfb : 24'h000000);
        d = m ? {24'({<<{e}}), k[275:0]} ^ x : k;
        check_mode = m;
        fork
            u_frm.send(d, m ? 300 : 276);
            for (int i = 0; i < 400 && c[25] !== 1'b1; i++)
                @(negedge clk) begin
                    if (out_valid && !out_parity && out_bit === d[n]) n++;
                    c = {msg_done, crc_error, out_valid && out_parity ? {c[22:0], out_bit} : c[23:0]};
                end
        join
        chk(c, {1'b1, m && x != 0, m ? 24'({<<{d[299:276]}}) : e});
        chk({15'h0000, busy, n}, {16'h0000, 10'h114});
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        run(1'b0, a, 300'h0);
        run(1'b0, ~a, 300'h0);
        run(1'b1, a, 300'h0);
        run(1'b1, a, 300'h1 << 3 | 300'h1 << 200);
        run(1'b1, a, 300'hffffff << 260);
        finish_test(0);
    end
    initial #100000 finish_test(1);
endmodule
`default_nettype wire
